/* File: hdl/rpc_clock_select.sv */
// Chosen here: the address decode and the APB register port; the offsets come from rpc_pkg.
`timescale 1ns/1ps
`default_nettype none
module rpc_clock_select #(
	parameter int LOCK_CYCLES = rpc_pkg::LOCK_CYCLES,
	parameter int DIV_THRESH_KHZ = 1000000
)
(
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// Pins and analog interface
	input wire logic CRYSTAL_SELECT_PIN_I,
	input wire logic ANALOG_LOCK_I,
	input wire logic [21:0] REF_FREQ_KHZ_I,
	output logic MULT_PATH_O,
	output logic INPUT_DIV_EN_O,
	output logic CRYSTAL_MODE_O,
	output logic [6:0] MULT_FACTOR_O,
	output logic [2:0] OSC_RANGE_O,
	output logic [2:0] PUMP_CODE_O,
	output logic [1:0] REPLICA_DRIVE_O,
	output logic REPLICA_EN_O,
	output logic LOCK_O,
	output logic IRQ_O
);
	localparam int ST_W = rpc_pkg::ST_WIDTH;
	localparam int N_PINS = 2;
	localparam int PIN_XSEL = 0;
	localparam int PIN_LOCK = 1;
	localparam int FREQ_W = 22;
	localparam rpc_pkg::rpc_drive_t RPC_OFF = rpc_pkg::RPC_DRIVE_OFF;

	// Parameter checks
	if (LOCK_CYCLES < 1)
	begin : g_bad_lock
		$error("LOCK_CYCLES must be at least 1");
	end
	if (DIV_THRESH_KHZ < 1 || DIV_THRESH_KHZ >= (1 << FREQ_W))
	begin : g_bad_thresh
		$error("DIV_THRESH_KHZ must fit the frequency input");
	end

	logic [31:0] control;
	wire [ST_W-1:0] status;
	logic [ST_W-1:0] mask;
	rpc_pkg::rpc_cfg_t cfg;
	wire [N_PINS-1:0] pin_raw;
	wire [N_PINS-1:0] pin_flt;
	logic xs_c;
	logic lk_ok;
	logic bypass;
	logic mult_on;
	logic cfg_ok;
	logic cfg_chg;
	logic hi_ref;
	logic [31:0] lock_cnt;
	logic locked;
	logic locked_d;
	logic wr_acc;
	logic rd_acc;
	logic rd_setup;
	logic hit_control;
	logic hit_status;
	logic hit_mask;
	logic hit_state;
	logic addr_ok;
	logic [ST_W-1:0] evt;
	logic [31:0] state_word;
	rpc_pkg::rpc_drive_t drive_sel;

	// Address decode
	assign hit_control = PADDR_I == rpc_pkg::OFS_CONTROL;
	assign hit_status = PADDR_I == rpc_pkg::OFS_STATUS;
	assign hit_mask = PADDR_I == rpc_pkg::OFS_MASK;
	assign hit_state = PADDR_I == rpc_pkg::OFS_STATE;
	assign addr_ok = hit_control | hit_status | hit_mask | hit_state;
	assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I;
	assign rd_acc = PSEL_I & PENABLE_I & ~PWRITE_I;
	assign rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;
	assign PREADY_O = 1'b1;
	// Unmapped offsets answer with an error
	assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_ok;

	assign cfg.replica_drive = control[rpc_pkg::RO_LSB +: 2];
	assign cfg.osc_range = control[rpc_pkg::OSC_LSB +: 3];
	assign cfg.pump_code = control[rpc_pkg::CP_LSB +: 3];
	assign cfg.div_en = control[rpc_pkg::DIV_EN_BIT];
	assign cfg.mult = control[rpc_pkg::MULT_LSB +: 7];
	assign cfg.pll_en = control[rpc_pkg::PLL_EN_BIT];
	assign cfg.crystal_sel = xs_c;

	// Control register write
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			control <= rpc_pkg::CONTROL_RESET;
		else if (wr_acc && PADDR_I == rpc_pkg::OFS_CONTROL)
			control <= PWDATA_I & rpc_pkg::CONTROL_MASK;
	end

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			mask <= '0;
		else if (wr_acc && PADDR_I == rpc_pkg::OFS_MASK)
			mask <= PWDATA_I[ST_W-1:0];
	end

	// Pin synchronisers, three flops then agreement filter
	assign pin_raw[PIN_XSEL] = CRYSTAL_SELECT_PIN_I;
	assign pin_raw[PIN_LOCK] = ANALOG_LOCK_I;
	for (genvar p = 0; p < N_PINS; p++)
	begin : g_sync
		logic s1;
		logic s2;
		logic s3;
		logic flt;
		always_ff @(posedge CLK_I or posedge RST_I)
		begin
			if (RST_I)
			begin
				s1 <= 1'b0;
				s2 <= 1'b0;
				s3 <= 1'b0;
			end
			else
			begin
				s1 <= pin_raw[p];
				s2 <= s1;
				s3 <= s2;
			end
		end
		// Level moves only once second and third agree
		always_ff @(posedge CLK_I or posedge RST_I)
		begin
			if (RST_I)
				flt <= 1'b0;
			else if (s2 == s3)
				flt <= s3;
		end
		assign pin_flt[p] = flt;
	end
	assign xs_c = pin_flt[PIN_XSEL];
	assign lk_ok = pin_flt[PIN_LOCK];

	assign bypass = cfg.osc_range == rpc_pkg::OSC_BYPASS_A
		|| cfg.osc_range == rpc_pkg::OSC_BYPASS_B;
	assign cfg_ok = cfg.mult >= rpc_pkg::MULT_MIN && cfg.mult <= rpc_pkg::MULT_MAX;
	assign mult_on = cfg.pll_en & ~bypass & cfg_ok;
	assign hi_ref = 32'(REF_FREQ_KHZ_I) > 32'(DIV_THRESH_KHZ);
	assign cfg_chg = wr_acc && PADDR_I == rpc_pkg::OFS_CONTROL
		&& (PWDATA_I & rpc_pkg::CONTROL_MASK) != control;

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			lock_cnt <= '0;
		else if (!mult_on || !lk_ok || cfg_chg)
			lock_cnt <= '0;
		else if (lock_cnt < 32'(LOCK_CYCLES))
			lock_cnt <= lock_cnt + 32'd1;
	end

	assign locked = mult_on && lock_cnt >= 32'(LOCK_CYCLES);

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			locked_d <= 1'b0;
		else
			locked_d <= locked;
	end

	assign evt[rpc_pkg::ST_LOCK_GAIN] = locked & ~locked_d;
	assign evt[rpc_pkg::ST_LOCK_LOSS] = ~locked & locked_d;
	assign evt[rpc_pkg::ST_CFG_ERR] = cfg.pll_en & ~bypass & ~cfg_ok;

	// Sticky status per bit, read clears, set wins
	for (genvar b = 0; b < ST_W; b++)
	begin : g_status
		logic sticky;
		always_ff @(posedge CLK_I or posedge RST_I)
		begin
			if (RST_I)
				sticky <= 1'b0;
			else if (evt[b])
				sticky <= 1'b1;
			else if (rd_acc && hit_status)
				sticky <= 1'b0;
		end
		assign status[b] = sticky;
	end

	// State word for software
	assign state_word = {26'h0, hi_ref, xs_c, bypass, cfg_ok, mult_on, locked};

	// Read data loaded in setup, events of that cycle included
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			PRDATA_O <= '0;
		else if (rd_setup)
		begin
			case (PADDR_I)
				rpc_pkg::OFS_CONTROL: PRDATA_O <= control;
				rpc_pkg::OFS_STATUS: PRDATA_O <= 32'(status | evt);
				rpc_pkg::OFS_MASK: PRDATA_O <= 32'(mask);
				rpc_pkg::OFS_STATE: PRDATA_O <= state_word;
				default: PRDATA_O <= '0;
			endcase
		end
	end

	always_comb
	begin
		drive_sel = RPC_OFF;
		if (mult_on)
			drive_sel = rpc_pkg::rpc_drive_t'(cfg.replica_drive);
	end

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			MULT_PATH_O <= 1'b0;
		else
			MULT_PATH_O <= mult_on;
	end

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			INPUT_DIV_EN_O <= 1'b0;
		else
			INPUT_DIV_EN_O <= cfg.div_en | (~mult_on & hi_ref);
	end

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			CRYSTAL_MODE_O <= 1'b0;
		else
			CRYSTAL_MODE_O <= cfg.crystal_sel;
	end

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			MULT_FACTOR_O <= rpc_pkg::MULT_MIN;
		else
			MULT_FACTOR_O <= cfg_ok ? cfg.mult : rpc_pkg::MULT_MIN;
	end

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			OSC_RANGE_O <= '0;
		else
			OSC_RANGE_O <= cfg.osc_range;
	end

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			PUMP_CODE_O <= '0;
		else
			PUMP_CODE_O <= cfg.pump_code;
	end

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			REPLICA_DRIVE_O <= '0;
		else
			REPLICA_DRIVE_O <= drive_sel;
	end

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			REPLICA_EN_O <= 1'b0;
		else
			REPLICA_EN_O <= drive_sel != RPC_OFF;
	end

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			LOCK_O <= 1'b0;
		else
			LOCK_O <= locked;
	end

	// Interrupt level from unmasked status
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
			IRQ_O <= 1'b0;
		else
			IRQ_O <= |(status & mask);
	end
endmodule : rpc_clock_select
`default_nettype wire

/* File: hdl/rpc_pkg.sv */
package rpc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_STATE = 8'h0C;
	// Control word field positions
	localparam int RO_LSB = 28;
	localparam int OSC_LSB = 24;
	localparam int CP_LSB = 19;
	localparam int MULT_LSB = 1;
	localparam int PLL_EN_BIT = 0;
	localparam int DIV_EN_BIT = 8;
	localparam int XSEL_BIT = 9;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	localparam logic [31:0] CONTROL_MASK = 32'h3738_01FF;
	// Multiplier and oscillator codes
	localparam logic [6:0] MULT_MIN = 7'h0C;
	localparam logic [6:0] MULT_MAX = 7'h7F;
	localparam logic [2:0] OSC_BYPASS_A = 3'h6;
	localparam logic [2:0] OSC_BYPASS_B = 3'h7;
	// Status bit positions
	localparam int ST_LOCK_GAIN = 0;
	localparam int ST_LOCK_LOSS = 1;
	localparam int ST_CFG_ERR = 2;
	localparam int ST_WIDTH = 3;
	// Lock settle time
	localparam int LOCK_TIME_US = 100;
	localparam int CLK_MHZ = 100;
	localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
	// Unpacked control word
	typedef struct packed {
		logic [1:0] replica_drive;
		logic [2:0] osc_range;
		logic [2:0] pump_code;
		logic crystal_sel;
		logic div_en;
		logic [6:0] mult;
		logic pll_en;
	} rpc_cfg_t;
	typedef enum logic [1:0] {
		RPC_DRIVE_OFF,
		RPC_DRIVE_LOW,
		RPC_DRIVE_MED,
		RPC_DRIVE_HIGH
	} rpc_drive_t;
endpackage : rpc_pkg

/* File: tb/rpc_ref_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rpc_ref_model (
	input wire logic clk_i,
	input wire logic path_on_i,
	input wire logic [6:0] factor_i,
	input wire logic hi_ref_i,
	output logic lock_o,
	output logic [21:0] khz_o
);
	logic [3:0] cnt = 4'h0;
	assign khz_o = hi_ref_i ? 22'h16E360 : 22'h0061A8;
	always_ff @(posedge clk_i)
	begin
		cnt <= (!path_on_i || factor_i != $past(factor_i)) ? 4'h0 : cnt + {3'h0, cnt != 4'hF};
		lock_o <= cnt > 4'h3;
	end
endmodule : rpc_ref_model
`default_nettype wire

/* File: tb/rpc_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module rpc_properties #(
	parameter int LOCK_CYCLES = 8
)
(
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic PSLVERR_O,
	input wire logic [21:0] REF_FREQ_KHZ_I,
	input wire logic MULT_PATH_O,
	input wire logic INPUT_DIV_EN_O,
	input wire logic [6:0] MULT_FACTOR_O,
	input wire logic [2:0] OSC_RANGE_O,
	input wire logic [1:0] REPLICA_DRIVE_O,
	input wire logic REPLICA_EN_O,
	input wire logic LOCK_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	sequence s_new_factor;
		PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 8'h00 && PWDATA_I[7:1] != MULT_FACTOR_O;
	endsequence
	AST_RELOCK: assert property (s_new_factor |=> ##1 !LOCK_O) else $error("lock kept");
	AST_BYPASS_LOW: assert property (OSC_RANGE_O[2:1] == 2'h3 |=> !LOCK_O) else $error("lock");
	AST_PATH_OFF: assert property (!MULT_PATH_O |=> !LOCK_O) else $error("lock off path");
	AST_PATH_CODES: assert property (MULT_PATH_O |-> OSC_RANGE_O < 3'h6 && MULT_FACTOR_O >= 7'h0C)
		else $error("bad path");
	AST_LOCK_PATH: assert property ($rose(LOCK_O) |-> MULT_PATH_O && $past(MULT_PATH_O, 8))
		else $error("early lock");
	AST_REPLICA: assert property (MULT_PATH_O && REPLICA_DRIVE_O != 2'h0 |-> REPLICA_EN_O)
		else $error("replica off");
	AST_DIV: assert property (!MULT_PATH_O && !$past(MULT_PATH_O) &&
		$past(REF_FREQ_KHZ_I) > 22'h0F4240 |-> INPUT_DIV_EN_O) else $error("divider off");
	AST_SLVERR: assert property (PSEL_I && PENABLE_I |-> PSLVERR_O == (PADDR_I > 8'h0C ||
		PADDR_I[1:0] != 2'h0)) else $error("slave error");
endmodule : rpc_properties
bind rpc_clock_select rpc_properties #(.LOCK_CYCLES(LOCK_CYCLES)) chk_u (.*);
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic CLK_I, RST_I, PSEL_I, PENABLE_I, PWRITE_I, ANALOG_LOCK_I, PREADY_O, PSLVERR_O;
	logic MULT_PATH_O, INPUT_DIV_EN_O, CRYSTAL_MODE_O, REPLICA_EN_O, LOCK_O, IRQ_O;
	logic CRYSTAL_SELECT_PIN_I = 1'b0;
	logic hi = 1'b0;
	logic [7:0] PADDR_I;
	logic [31:0] PWDATA_I, PRDATA_O, d, st = 32'h3E74;
	logic [21:0] REF_FREQ_KHZ_I;
	logic [6:0] MULT_FACTOR_O;
	logic [2:0] OSC_RANGE_O, PUMP_CODE_O;
	logic [1:0] REPLICA_DRIVE_O;
	logic [31:0] q[$];
	int n_errors = 0;
	int n_tests = 0;
	rpc_clock_select #(.LOCK_CYCLES(8)) dut_u (.*);
	rpc_ref_model ref_u (.clk_i(CLK_I), .path_on_i(MULT_PATH_O), .factor_i(MULT_FACTOR_O),
		.hi_ref_i(hi), .lock_o(ANALOG_LOCK_I), .khz_o(REF_FREQ_KHZ_I));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x)
		begin
			n_errors++;
			$display("BAD t=%0t seen %h exp %h", $time, s, x);
		end
	endtask : chk
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] v);
		@(posedge CLK_I);
		PADDR_I <= a;
		PWRITE_I <= w;
		PWDATA_I <= v;
		PSEL_I <= 1'b1;
		@(posedge CLK_I);
		PENABLE_I <= 1'b1;
		@(posedge CLK_I);
		while (PREADY_O !== 1'b1)
			@(posedge CLK_I);
		PSEL_I <= 1'b0;
		PENABLE_I <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		q.push_back(x);
		apb(a, 1'b0, 32'h0);
	endtask : rd
	task automatic test_done();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	always @(posedge CLK_I)
		if (PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I)
			chk(PRDATA_O, q.pop_front());
	initial
	begin
		CLK_I = 1'b0;
		forever #5 CLK_I = ~CLK_I;
	end
	initial
	begin
		#50000;
		n_errors++;
		test_done();
	end
	initial
	begin
		{RST_I, PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I} = {4'h8, 40'h0};
		repeat (5) @(posedge CLK_I);
		chk(32'(MULT_FACTOR_O), 32'h0C);
		RST_I <= 1'b0;
		rd(8'h00, 32'h0);
		$display("reset done");
		apb(8'h08, 1'b1, 32'h1);
		apb(8'h00, 1'b1, 32'h2328_0033);
		rd(8'h00, 32'h2328_0033);
		for (int i = 0; i < 60 && LOCK_O !== 1'b1; i++)
			@(posedge CLK_I);
		@(negedge CLK_I);
		chk(32'({MULT_FACTOR_O, MULT_PATH_O, REPLICA_EN_O, LOCK_O, IRQ_O, OSC_RANGE_O,
			PUMP_CODE_O, REPLICA_DRIVE_O}), 32'({7'h19, 4'hF, 3'h3, 3'h5, 2'h2}));
		rd(8'h04, 32'h1);
		repeat (2) @(posedge CLK_I);
		chk(32'(IRQ_O), 32'h0);
		$display("lock done");
		for (int i = 6; i < 8; i++)
		begin
			apb(8'h00, 1'b1, 32'h33 | (32'(i) << 24));
			repeat (3) @(posedge CLK_I);
			chk(32'({MULT_PATH_O, LOCK_O}), 32'h0);
		end
		hi <= 1'b1;
		apb(8'h00, 1'b1, 32'h0);
		repeat (3) @(posedge CLK_I);
		chk(32'(INPUT_DIV_EN_O), 32'h1);
		hi <= 1'b0;
		$display("bypass done");
		CRYSTAL_SELECT_PIN_I <= 1'b1;
		repeat (8) @(posedge CLK_I);
		chk(32'(CRYSTAL_MODE_O), 32'h1);
		repeat (6)
		begin
			st = xs(st);
			d = st & 32'h3738_01FF;
			apb(8'h00, 1'b1, d);
			rd(8'h00, d);
			chk(32'(MULT_PATH_O), 32'(d[0] && d[7:1] >= 7'h0C && d[26:25] != 2'h3));
		end
		rd(8'h10, 32'h0);
		$display("random done");
		repeat (2) @(posedge CLK_I);
		test_done();
	end
endmodule : testbench
`default_nettype wire
